// ### core/option_bank_params.svh
// constants for the option bit bank: offsets, fields, resets, timing
`ifndef OPTION_BANK_PARAMS_SVH
`define OPTION_BANK_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_PD_A       6'h10
`define IDX_PD_B       6'h11
`define IDX_BANK_ONE   6'h12
`define IDX_BANK_TWO   6'h13
`define IDX_RSVD_A     6'h14
`define IDX_STATUS     6'h15
`define IDX_RSVD_B     6'h1f

// option bank one fields
`define BIT_WDOG       0
`define BIT_LEVEL      1
`define BIT_PORT_IRQ   2
`define BIT_PD_INH     3
`define BIT_STOP_CONV  4
`define BIT_RC_OSC     5
`define BIT_THREE_PIN  6
`define BIT_STARTUP    7
// option bank two fields
`define BIT_SEC_LO     0
`define BIT_SEC_HI     1
// status fields
`define BIT_ST_SUSP    0
`define BIT_ST_BUSY    1
`define LSB_ST_COUNT   8

// reset values; erased cells are zero
`define RST_CELLS      16'h0000
`define RST_PD         8'h00

// startup waits in operating-clock cycles
`define WAIT_LONG      12'hfe0
`define WAIT_SHORT     12'h010

// reload period and nominal ring oscillator period
`define RELOAD_US      1000
`define RING_NS        1000

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ### core/option_bank_pkg.sv
// types shared by the option bit bank
package option_bank_pkg;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_FETCH    = 2'b01,
		ST_LOAD_ONE = 2'b10,
		ST_LOAD_TWO = 2'b11
	} reload_state_e;

endpackage

// ### core/option_cell_store.sv
// nonvolatile option cell image with a registered read port
module option_cell_store #(
	parameter int                 WIDTH = 8,
	parameter int                 DEPTH = 2,
	parameter logic [WIDTH*DEPTH-1:0] INIT = '0
) (
	input  wire logic                     i_clock,
	input  wire logic                     i_nrst,
	input  wire logic                     i_wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
	input  wire logic [WIDTH-1:0]         i_wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
	output logic      [WIDTH-1:0]         o_rd_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] cell_r [DEPTH];

	// reset stands in for the cells' stored content
	for (genvar g = 0; g < DEPTH; g++) begin : g_cell
		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst)
				cell_r[g] <= INIT[g*WIDTH +: WIDTH];
			else if (i_wr_en && i_wr_addr == AW'(g))
				cell_r[g] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			o_rd_data <= '0;
		else
			o_rd_data <= cell_r[i_rd_addr];
	end

endmodule

// ### core/mask_option_config_bank.sv
// option bit bank: cell refresh, option outputs, axi4-lite registers
`include "option_bank_params.svh"

module mask_option_config_bank #(
	parameter int RING_PERIOD_NS = `RING_NS,
	parameter int RELOAD_US      = `RELOAD_US
) (
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	input  wire logic        i_ring_osc,
	input  wire logic        i_stop_mode,
	input  wire logic        i_cell_program,
	input  wire logic        i_user_mode,
	input  wire logic        i_irq_n,
	input  wire logic [3:0]  i_port_a_low,
	input  wire logic        i_irq_ack,
	output logic             o_watchdog_enable,
	output logic             o_level_sense,
	output logic             o_port_irq_source,
	output logic             o_pulldown_inhibit,
	output logic             o_stop_conversion,
	output logic             o_rc_osc,
	output logic             o_three_terminal_osc,
	output logic [11:0]      o_startup_wait,
	output logic             o_nvm_protect,
	output logic [7:0]       o_port_a_pd_en,
	output logic [1:0]       o_port_b_pd_en,
	output logic             o_irq_request
);

	localparam int EDGES_RAW = (RELOAD_US * 1000) / RING_PERIOD_NS;
	localparam int RELOAD_EDGES = (EDGES_RAW < 1) ? 1 : EDGES_RAW;
	localparam int CW = $clog2(RELOAD_EDGES + 1);

	////////////////////////////////////////////////////////////////////////
	// declarations

	option_bank_pkg::reload_state_e state_r;
	logic [CW-1:0] ring_cnt_r;
	logic          ring_q_r;
	logic          ring_rise;
	logic          reload_tick;
	logic          suspended;
	logic [7:0]    bank_one_r;
	logic [1:0]    bank_two_r;
	logic [7:0]    reload_cnt_r;
	logic [7:0]    cell_rd_data;
	logic          cell_rd_addr;
	logic          cell_wr_en;
	logic [7:0]    pd_a_r;
	logic [1:0]    pd_b_r;
	logic          aw_full_r;
	logic          w_full_r;
	logic [5:0]    aw_idx_r;
	logic [31:0]   w_data_r;
	logic [3:0]    w_strb_r;
	logic          wr_fire;
	logic [5:0]    ar_idx;
	logic [31:0]   rd_word;
	logic [1:0]    rd_resp;
	logic          irq_q_r;
	logic [3:0]    pa_q_r;
	logic          irq_latch_r;
	logic          latch_set;
	logic          level_req;

	////////////////////////////////////////////////////////////////////////
	// ring-paced reload timing

	// the ring oscillator is slow next to i_clock, so its edges are counted
	assign ring_rise = i_ring_osc & ~ring_q_r;
	assign suspended = i_stop_mode | i_cell_program | cell_wr_en;
	assign reload_tick = ring_rise &&
		(ring_cnt_r == CW'(RELOAD_EDGES - 1));

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			ring_q_r <= 1'b0;
		else
			ring_q_r <= i_ring_osc;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			ring_cnt_r <= '0;
		else if (reload_tick)
			ring_cnt_r <= '0;
		else if (ring_rise)
			ring_cnt_r <= ring_cnt_r + CW'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// reload sequence

	// a tick that lands during suspension is dropped, not deferred
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= option_bank_pkg::ST_FETCH;
		end else if (suspended) begin
			state_r <= option_bank_pkg::ST_IDLE;
		end else begin
			case (state_r)
			option_bank_pkg::ST_IDLE: begin
				if (reload_tick)
					state_r <= option_bank_pkg::ST_FETCH;
			end
			option_bank_pkg::ST_FETCH: begin
				state_r <= option_bank_pkg::ST_LOAD_ONE;
			end
			option_bank_pkg::ST_LOAD_ONE: begin
				state_r <= option_bank_pkg::ST_LOAD_TWO;
			end
			default: begin
				state_r <= option_bank_pkg::ST_IDLE;
			end
			endcase
		end
	end

	assign cell_rd_addr = (state_r == option_bank_pkg::ST_LOAD_ONE);

	// visible bits change only at a load step, otherwise they hold
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			bank_one_r <= 8'(`RST_CELLS);
			bank_two_r <= '0;
		end else if (!suspended) begin
			if (state_r == option_bank_pkg::ST_LOAD_ONE)
				bank_one_r <= cell_rd_data;
			if (state_r == option_bank_pkg::ST_LOAD_TWO)
				bank_two_r <= cell_rd_data[1:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			reload_cnt_r <= '0;
		else if (!suspended && state_r == option_bank_pkg::ST_LOAD_TWO)
			reload_cnt_r <= reload_cnt_r + 8'h01;
	end

	// erased cells hold zero, so unprogrammed options read as zero
	option_cell_store #(
		.WIDTH (8),
		.DEPTH (2),
		.INIT  (`RST_CELLS)
	) u_cells (
		.i_clock   (i_clock),
		.i_nrst    (i_nrst),
		.i_wr_en   (cell_wr_en),
		.i_wr_addr (aw_idx_r == `IDX_BANK_TWO),
		.i_wr_data (w_data_r[7:0]),
		.i_rd_addr (cell_rd_addr),
		.o_rd_data (cell_rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// option outputs

	assign o_watchdog_enable    = bank_one_r[`BIT_WDOG];
	assign o_level_sense        = bank_one_r[`BIT_LEVEL];
	assign o_port_irq_source    = bank_one_r[`BIT_PORT_IRQ];
	assign o_pulldown_inhibit   = bank_one_r[`BIT_PD_INH];
	assign o_stop_conversion    = bank_one_r[`BIT_STOP_CONV];
	assign o_rc_osc             = bank_one_r[`BIT_RC_OSC];
	assign o_three_terminal_osc = bank_one_r[`BIT_THREE_PIN];

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_startup_wait <= `WAIT_LONG;
			o_nvm_protect  <= 1'b1;
		end else begin
			o_startup_wait <= bank_one_r[`BIT_STARTUP] ?
				`WAIT_SHORT : `WAIT_LONG;
			o_nvm_protect  <= ~bank_two_r[`BIT_SEC_HI];
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_port_a_pd_en <= '0;
			o_port_b_pd_en <= '0;
		end else begin
			o_port_a_pd_en <= ~pd_a_r &
				{8{~bank_one_r[`BIT_PD_INH]}};
			o_port_b_pd_en <= ~pd_b_r &
				{2{~bank_one_r[`BIT_PD_INH]}};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt sensing

	assign latch_set = (irq_q_r & ~i_irq_n) ||
		(bank_one_r[`BIT_PORT_IRQ] && |(i_port_a_low & ~pa_q_r));
	assign level_req = bank_one_r[`BIT_LEVEL] && (~i_irq_n ||
		(bank_one_r[`BIT_PORT_IRQ] && |i_port_a_low));

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_q_r <= 1'b1;
			pa_q_r  <= '0;
		end else begin
			irq_q_r <= i_irq_n;
			pa_q_r  <= i_port_a_low;
		end
	end

	// a new edge in the acknowledge cycle still sets the latch
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			irq_latch_r <= 1'b0;
		else if (latch_set)
			irq_latch_r <= 1'b1;
		else if (i_irq_ack)
			irq_latch_r <= 1'b0;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			o_irq_request <= 1'b0;
		else
			o_irq_request <= irq_latch_r | level_req;
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write side

	assign wr_fire = aw_full_r && w_full_r && !o_bvalid;
	// option slots only take writes outside user mode, into the cells
	assign cell_wr_en = wr_fire && !i_user_mode &&
		w_strb_r[0] && (aw_idx_r == `IDX_BANK_ONE ||
		aw_idx_r == `IDX_BANK_TWO);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_awready <= 1'b1;
			aw_full_r <= 1'b0;
			aw_idx_r  <= '0;
		end else if (i_awvalid && o_awready) begin
			o_awready <= 1'b0;
			aw_full_r <= 1'b1;
			aw_idx_r  <= i_awaddr[7:2];
		end else if (wr_fire) begin
			aw_full_r <= 1'b0;
		end else if (o_bvalid && i_bready) begin
			o_awready <= 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wready <= 1'b1;
			w_full_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (i_wvalid && o_wready) begin
			o_wready <= 1'b0;
			w_full_r <= 1'b1;
			w_data_r <= i_wdata;
			w_strb_r <= i_wstrb;
		end else if (wr_fire) begin
			w_full_r <= 1'b0;
		end else if (o_bvalid && i_bready) begin
			o_wready <= 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_bvalid <= 1'b0;
			o_bresp  <= `RESP_OKAY;
		end else if (wr_fire) begin
			o_bvalid <= 1'b1;
			if (aw_idx_r == `IDX_PD_A || aw_idx_r == `IDX_PD_B ||
				aw_idx_r == `IDX_BANK_ONE || aw_idx_r == `IDX_BANK_TWO ||
				aw_idx_r == `IDX_RSVD_A || aw_idx_r == `IDX_RSVD_B ||
				aw_idx_r == `IDX_STATUS)
				o_bresp <= `RESP_OKAY;
			else
				o_bresp <= `RESP_SLVERR;
		end else if (o_bvalid && i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			pd_a_r <= `RST_PD;
			pd_b_r <= '0;
		end else if (wr_fire && w_strb_r[0]) begin
			if (aw_idx_r == `IDX_PD_A)
				pd_a_r <= w_data_r[7:0];
			else if (aw_idx_r == `IDX_PD_B)
				pd_b_r <= w_data_r[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read side

	assign ar_idx = i_araddr[7:2];

	always_comb begin
		rd_word = '0;
		rd_resp = `RESP_OKAY;
		if (ar_idx == `IDX_BANK_ONE) begin
			rd_word[7:0] = bank_one_r;
		end else if (ar_idx == `IDX_BANK_TWO) begin
			rd_word[1:0] = bank_two_r;
		end else if (ar_idx == `IDX_STATUS) begin
			rd_word[`BIT_ST_SUSP] = suspended;
			rd_word[`BIT_ST_BUSY] = (state_r != option_bank_pkg::ST_IDLE);
			rd_word[`LSB_ST_COUNT +: 8] = reload_cnt_r;
		end else if (ar_idx == `IDX_PD_A || ar_idx == `IDX_PD_B ||
			ar_idx == `IDX_RSVD_A || ar_idx == `IDX_RSVD_B) begin
			rd_word = '0;
		end else begin
			rd_resp = `RESP_SLVERR;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= '0;
			o_rresp   <= `RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rdata   <= rd_word;
			o_rresp   <= rd_resp;
		end else if (o_rvalid && i_rready) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
		end
	end

endmodule

// ### verif/mask_option_config_bank_props.sv
// port checker for the option bit bank
module mask_option_config_bank_props (
	input wire logic        i_clock,
	input wire logic        i_nrst,
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic        i_stop_mode,
	input wire logic        i_irq_n,
	input wire logic        o_irq_request,
	input wire logic [11:0] o_startup_wait,
	input wire logic        o_watchdog_enable,
	input wire logic        o_level_sense,
	input wire logic        o_pulldown_inhibit,
	input wire logic [7:0]  o_port_a_pd_en,
	input wire logic [1:0]  o_port_b_pd_en
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);
	////////////////////////////////////////
	sequence s_wr_take;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	// response flop lands one edge after the taken pair is registered
	sequence s_wr_answer;
		!o_awready && !o_wready ##1 o_bvalid;
	endsequence
	sequence s_rd_take;
		i_arvalid && o_arready;
	endsequence
	a_wr_answer:
		assert property (s_wr_take |=> s_wr_answer)
		else $error("write answer missing");
	a_rd_answer:
		assert property (s_rd_take |=> o_rvalid && !o_arready)
		else $error("read answer missing");
	a_b_release:
		assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready)
		else $error("write response not released");
	a_r_release:
		assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
		else $error("read data not released");
	a_wait_values:
		assert property (o_startup_wait == 12'hfe0 || o_startup_wait == 12'h010)
		else $error("startup wait not a legal count");
	a_stop_holds:
		assert property (i_stop_mode [*3] |->
			$stable({o_watchdog_enable, o_level_sense, o_startup_wait}))
		else $error("options moved during stop");
	a_irq_fall:
		assert property ($fell(i_irq_n) |-> ##[1:3] o_irq_request)
		else $error("irq pin fall not latched");
	a_pd_inhibit:
		assert property (o_pulldown_inhibit && $past(o_pulldown_inhibit) |->
			o_port_a_pd_en == 8'h00 && o_port_b_pd_en == 2'h0)
		else $error("pulldown enabled while inhibited");
endmodule

bind mask_option_config_bank mask_option_config_bank_props i_props (
	.i_clock, .i_nrst, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
	.o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .i_rready,
	.i_stop_mode, .i_irq_n, .o_irq_request, .o_startup_wait,
	.o_watchdog_enable, .o_level_sense, .o_pulldown_inhibit,
	.o_port_a_pd_en, .o_port_b_pd_en
);

// ### verif/mask_option_config_bank_tb.sv
// self-checking bench for the option bit bank
`include "option_bank_params.svh"
module mask_option_config_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock, i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid;
	logic i_rready, i_ring_osc, i_stop_mode, i_cell_program;
	logic i_user_mode, i_irq_n, i_irq_ack;
	logic [7:0] i_awaddr, i_araddr, o_port_a_pd_en;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0] i_wstrb, i_port_a_low;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp, o_port_b_pd_en;
	logic o_watchdog_enable, o_level_sense, o_port_irq_source;
	logic o_pulldown_inhibit, o_stop_conversion, o_rc_osc;
	logic o_three_terminal_osc, o_nvm_protect, o_irq_request;
	logic [11:0] o_startup_wait;
	int errors, compares;

	// one ring edge per reload keeps the run short
	mask_option_config_bank #(.RING_PERIOD_NS(1000), .RELOAD_US(1)) i_dut (
		.i_clock, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
		.i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
		.i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
		.i_rready, .i_ring_osc, .i_stop_mode, .i_cell_program, .i_user_mode,
		.i_irq_n, .i_port_a_low, .i_irq_ack, .o_watchdog_enable,
		.o_level_sense, .o_port_irq_source, .o_pulldown_inhibit,
		.o_stop_conversion, .o_rc_osc, .o_three_terminal_osc,
		.o_startup_wait, .o_nvm_protect, .o_port_a_pd_en, .o_port_b_pd_en,
		.o_irq_request
	);

	initial begin
		i_clock = 1'h0;
		forever #20 i_clock = ~i_clock;
	end
	////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] ix, input logic [7:0] d,
		input logic [1:0] er);
		logic done;
		@(posedge i_clock);
		i_awaddr <= {ix, 2'h0};
		i_wdata <= {24'h0, d};
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		done = 1'h0;
		while (!done) begin
			@(posedge i_clock);
			if (i_awvalid && o_awready) i_awvalid <= 1'h0;
			if (i_wvalid && o_wready) i_wvalid <= 1'h0;
			if (o_bvalid) begin
				i_bready <= 1'h0;
				chk("bresp", {30'h0, er}, {30'h0, o_bresp});
				done = 1'h1;
			end
		end
	endtask
	task automatic rd(input logic [5:0] ix, input logic [31:0] ed,
		input logic [1:0] er);
		logic done;
		@(posedge i_clock);
		i_araddr <= {ix, 2'h0};
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		done = 1'h0;
		while (!done) begin
			@(posedge i_clock);
			if (i_arvalid && o_arready) i_arvalid <= 1'h0;
			if (o_rvalid) begin
				i_rready <= 1'h0;
				chk("rdata", ed, o_rdata);
				chk("rresp", {30'h0, er}, {30'h0, o_rresp});
				done = 1'h1;
			end
		end
	endtask
	task automatic tick();
		@(posedge i_clock) i_ring_osc <= 1'h1;
		repeat (3) @(posedge i_clock);
		i_ring_osc <= 1'h0;
		repeat (8) @(posedge i_clock);
	endtask
	task automatic chk_opt(input logic [7:0] e);
		chk("options", {24'h0, e}, {24'h0, o_startup_wait === 12'h010,
			o_three_terminal_osc, o_rc_osc, o_stop_conversion,
			o_pulldown_inhibit, o_port_irq_source, o_level_sense,
			o_watchdog_enable});
		chk("wait", e[7] ? 32'h10 : 32'hfe0, {20'h0, o_startup_wait});
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		chk_opt(8'h00);
		chk("protect", 32'h1, {31'h0, o_nvm_protect});
		rd(`IDX_BANK_ONE, 32'h0, `RESP_OKAY);
		rd(`IDX_RSVD_B, 32'h0, `RESP_OKAY);
		rd(6'h16, 32'h0, `RESP_SLVERR);
		wr(6'h16, 8'h00, `RESP_SLVERR);
		rd(`IDX_STATUS, 32'h100, `RESP_OKAY);
		$display("reset test done");
	endtask
	task automatic t_walk();
		for (int i = 0; i < 8; i++) begin
			wr(`IDX_BANK_ONE, 8'h01 << i, `RESP_OKAY);
			chk_opt(i == 0 ? 8'h00 : 8'h01 << (i - 1));
			tick();
			chk_opt(8'h01 << i);
			rd(`IDX_BANK_ONE, 32'h1 << i, `RESP_OKAY);
		end
		$display("walk test done");
	endtask
	task automatic t_suspend();
		i_user_mode <= 1'h1;
		wr(`IDX_BANK_ONE, 8'h00, `RESP_OKAY);
		tick();
		chk_opt(8'h80);
		i_user_mode <= 1'h0;
		wr(`IDX_BANK_ONE, 8'h04, `RESP_OKAY);
		i_stop_mode <= 1'h1;
		tick();
		chk_opt(8'h80);
		i_stop_mode <= 1'h0;
		i_cell_program <= 1'h1;
		tick();
		chk_opt(8'h80);
		i_cell_program <= 1'h0;
		tick();
		chk_opt(8'h04);
		wr(`IDX_PD_B, 8'h01, `RESP_OKAY);
		wr(`IDX_PD_A, 8'h0f, `RESP_OKAY);
		repeat (2) @(posedge i_clock);
		chk("pd_a", 32'hf0, {24'h0, o_port_a_pd_en});
		chk("pd_b", 32'h2, {30'h0, o_port_b_pd_en});
		$display("suspend test done");
	endtask
	task automatic t_secure();
		for (int c = 0; c < 4; c++) begin
			wr(`IDX_BANK_TWO, c[7:0], `RESP_OKAY);
			tick();
			chk("protect", {31'h0, ~c[1]}, {31'h0, o_nvm_protect});
			rd(`IDX_BANK_TWO, c, `RESP_OKAY);
		end
		$display("security test done");
	endtask
	task automatic t_irq();
		// edge only, port pins enabled as sources
		@(posedge i_clock) i_irq_n <= 1'h0;
		repeat (4) @(posedge i_clock);
		chk("irq", 32'h1, {31'h0, o_irq_request});
		i_irq_ack <= 1'h1;
		@(posedge i_clock) i_irq_ack <= 1'h0;
		repeat (3) @(posedge i_clock);
		// pin still low: edge-only mode must not request again
		chk("irq", 32'h0, {31'h0, o_irq_request});
		i_irq_n <= 1'h1;
		i_port_a_low <= 4'h2;
		repeat (4) @(posedge i_clock);
		chk("irq", 32'h1, {31'h0, o_irq_request});
		// level option on, port sources off, ack held high throughout
		i_irq_ack <= 1'h1;
		i_port_a_low <= 4'h0;
		wr(`IDX_BANK_ONE, 8'h02, `RESP_OKAY);
		tick();
		i_irq_n <= 1'h0;
		repeat (4) @(posedge i_clock);
		chk("irq_lvl", 32'h1, {31'h0, o_irq_request});
		i_irq_ack <= 1'h0;
		i_irq_n <= 1'h1;
		$display("irq test done");
	endtask
	////////////////////////////////////////
	initial begin
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
		{i_ring_osc, i_stop_mode, i_cell_program, i_user_mode} = 4'h0;
		{i_irq_ack, i_irq_n, i_nrst} = 3'h2;
		i_awaddr = 8'h0;
		i_araddr = 8'h0;
		i_wdata = 32'h0;
		i_wstrb = 4'hf;
		i_port_a_low = 4'h0;
		errors = 0;
		compares = 0;
		repeat (16) @(posedge i_clock);
		i_nrst <= 1'h1;
		repeat (4) @(posedge i_clock);
		t_reset();
		t_walk();
		t_suspend();
		t_secure();
		t_irq();
		final_report();
	end
	initial begin
		#(40 * 20000);
		errors++;
		final_report();
	end
endmodule
